// ### bench/rtc_pad_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// driver pad seen by the antenna network
// ****************************************
module rtc_pad_model (
    // clock
    input  wire logic clock,
    // pin from the driver
    input  wire logic pinOut,
    input  wire logic pinOe,
    // resolved pad level
    output var  logic padLevel
);
    logic lastQ = 1'b0;

    // a released pad has no pull, so show the inverse of the last driven
    // level; tracking only driven cycles keeps a released pad from toggling
    always_ff @(posedge clock) begin
        if (pinOe) begin
            lastQ <= pinOut;
        end
    end

    always_comb begin
        padLevel = pinOe ? pinOut : ~lastQ;
    end
endmodule : rtc_pad_model

`default_nettype wire

// ### bench/rtc_tx_config_properties.sv
`timescale 1ns/100ps
`default_nettype none

module rtc_tx_config_properties (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic [7:0]  regWriteData,
    input  wire logic        regRead,
    input  wire logic [7:0]  regReadData,
    input  wire logic        regReadValid,
    // pins and analog controls
    input  wire logic        firstDriverPinOe,
    input  wire logic        secondDriverPinOe,
    input  wire logic [1:0]  carrierLevelReduction,
    input  wire logic        carrierAtMaximum,
    input  wire logic [10:0] carrierDropMv,
    input  wire logic [4:0]  residualCarrierSetting
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    property p_read_valid; regRead |=> regReadValid; endproperty
    a_read_valid: assert property (p_read_valid) else $error("read not answered");
    property p_no_stray_valid; !regRead |=> !regReadValid; endproperty
    a_no_stray_valid: assert property (p_no_stray_valid) else $error("stray read valid");
    property p_unmapped_zero;
        regRead && (regAddr < 8'h28 || regAddr > 8'h2A) |=> regReadData == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
    property p_reserved_zero; // reserved drive-mode bits 5:4 never read back set
        regRead && regAddr == 8'h28 ##1 1 |-> regReadData[5:4] == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");
    property p_max_override;
        carrierAtMaximum |-> carrierLevelReduction == 2'h0 && carrierDropMv == 11'h000;
    endproperty
    a_max_override: assert property (p_max_override) else $error("maximum not overriding");
    property p_drop_table;
        !carrierAtMaximum |-> carrierDropMv == (carrierLevelReduction == 2'h0 ? 11'h064 :
            carrierLevelReduction == 2'h1 ? 11'h0FA :
            carrierLevelReduction == 2'h2 ? 11'h1F4 : 11'h3E8);
    endproperty
    a_drop_table: assert property (p_drop_table) else $error("carrier drop wrong");
    property p_residual;
        regWrite && regAddr == 8'h29 |-> ##2 residualCarrierSetting == $past(regWriteData[4:0], 2);
    endproperty
    a_residual: assert property (p_residual) else $error("residual not passed on");
    property p_max_bit;
        regWrite && regAddr == 8'h2A |-> ##2 carrierAtMaximum == $past(regWriteData[3], 2);
    endproperty
    a_max_bit: assert property (p_max_bit) else $error("maximum bit not followed");
    property p_disable_pins;
        regWrite && regAddr == 8'h28 && (!regWriteData[3] || regWriteData[2:0] == 3'h0)
            |-> ##2 !firstDriverPinOe && !secondDriverPinOe;
    endproperty
    a_disable_pins: assert property (p_disable_pins) else $error("pins driven");
endmodule : rtc_tx_config_properties

bind rtc_tx_config rtc_tx_config_properties u_rtc_tx_config_properties (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
    .regWriteData(regWriteData), .regRead(regRead), .regReadData(regReadData),
    .regReadValid(regReadValid), .firstDriverPinOe(firstDriverPinOe),
    .secondDriverPinOe(secondDriverPinOe), .carrierLevelReduction(carrierLevelReduction),
    .carrierAtMaximum(carrierAtMaximum), .carrierDropMv(carrierDropMv),
    .residualCarrierSetting(residualCarrierSetting)
);

`default_nettype wire

// ### bench/rtc_tx_config_tb.sv
`timescale 1ns/100ps
`default_nettype none

module rtc_tx_config_tb;
    import rtc_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWriteData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic env = 1'b0;
    logic ext = 1'b0;
    logic [7:0] rdData;
    logic rdValid;
    logic out1, oe1, out2, oe2, pad1, pad2, atMax, modAct;
    logic [1:0] red;
    logic [10:0] dropMv;
    logic [4:0] resid;
    int errors = 0;
    int n_tests = 0;

    always #2.5 clock = ~clock;

    rtc_tx_config u_rtc_tx_config (
        .clock(clock), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
        .regWriteData(regWriteData), .regRead(regRead), .regReadData(rdData),
        .regReadValid(rdValid), .internalTransmitEnvelope(env), .externalSignalInput(ext),
        .firstDriverPinOut(out1), .firstDriverPinOe(oe1), .secondDriverPinOut(out2),
        .secondDriverPinOe(oe2), .carrierLevelReduction(red), .carrierAtMaximum(atMax),
        .carrierDropMv(dropMv), .residualCarrierSetting(resid), .modulationActive(modAct)
    );
    rtc_pad_model u_pad1 (.clock(clock), .pinOut(out1), .pinOe(oe1), .padLevel(pad1));
    rtc_pad_model u_pad2 (.clock(clock), .pinOut(out2), .pinOe(oe2), .padLevel(pad2));

    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regWriteData = d;
        regWrite = 1'b1;
        @(negedge clock);
        regWrite = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clock);
        // valid and data stand for one cycle only, so look before the next edge
        chk("read valid", 11'h001, {10'h000, rdValid});
        chk("read data", {3'h0, exp}, {3'h0, rdData});
        regRead = 1'b0;
    endtask : rd

    task automatic settle();
        repeat (4) @(negedge clock);
    endtask : settle

    task automatic t_regs();
        rd(ADDR_DRIVE_MODE, 8'h00);
        rd(ADDR_AMPLITUDE, 8'h00);
        rd(ADDR_MOD_CONTROL, 8'h00);
        chk("drop after reset", 11'h064, dropMv);
        wr(ADDR_DRIVE_MODE, 8'hFF);
        wr(ADDR_AMPLITUDE, 8'hFF);
        wr(ADDR_MOD_CONTROL, 8'hFE);
        wr(8'h2B, 8'h55);
        rd(ADDR_DRIVE_MODE, 8'hCF);
        rd(ADDR_AMPLITUDE, 8'hDF);
        rd(ADDR_MOD_CONTROL, 8'hFE);
        rd(8'h2B, 8'h00);
        $display("test regs done");
    endtask : t_regs

    task automatic t_amp();
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_MOD_CONTROL, 8'h00);
            wr(ADDR_AMPLITUDE, {c[1:0], 1'b1, 5'h11 ^ 5'(c)});
            settle();
            chk("reduction", 11'(c), {9'h000, red});
            chk("drop", c == 0 ? DROP_MV_0 : c == 1 ? DROP_MV_1 : c == 2 ? DROP_MV_2 : DROP_MV_3, dropMv);
            chk("residual", 11'h11 ^ 11'(c), {6'h00, resid});
        end
        wr(ADDR_MOD_CONTROL, 8'h08);
        settle();
        chk("at maximum", 11'h001, {10'h000, atMax});
        chk("drop at maximum", 11'h000, dropMv);
        $display("test amplitude done");
    endtask : t_amp

    task automatic t_pins();
        logic [7:0] modes [4] = '{8'h0C, 8'h0D, 8'h08, 8'h02};
        logic [1:0] expOut [4] = '{2'b00, 2'b11, 2'b00, 2'b00};
        logic [1:0] expOe [4] = '{2'b11, 2'b11, 2'b00, 2'b00};
        env = 1'b1;
        wr(ADDR_MOD_CONTROL, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_DRIVE_MODE, {i[1:0], 6'h0A});
            settle();
            chk("pin one", 11'(i[0]), {10'h000, pad1});
            chk("pin two", 11'(i[1]), {10'h000, pad2});
            chk("pins on", 11'h003, {9'h000, oe2, oe1});
        end
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_DRIVE_MODE, modes[i]);
            settle();
            chk("mode oe", 11'(expOe[i]), {9'h000, oe2, oe1});
            if (expOe[i] == 2'b11) begin
                chk("mode level", 11'(expOut[i]), {9'h000, pad2, pad1});
            end
        end
        wr(ADDR_DRIVE_MODE, 8'h09);
        settle();
        chk("open drain", 11'h003, {9'h000, oe2, oe1});
        chk("open drain low", 11'h000, {9'h000, pad2, pad1});
        $display("test pins done");
    endtask : t_pins

    task automatic t_mod();
        logic [7:0] ctl [6] = '{8'h00, 8'h01, 8'h02, 8'h02, 8'h06, 8'h05};
        logic [1:0] ins [6] = '{2'b11, 2'b01, 2'b10, 2'b00, 2'b00, 2'b00};
        logic       exp [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_MOD_CONTROL, ctl[i]);
            env = ins[i][0];
            ext = ins[i][1];
            settle();
            chk("modulation", 11'(exp[i]), {10'h000, modAct});
        end
        $display("test modulation done");
    endtask : t_mod

    task automatic t_overshoot();
        int n;
        wr(ADDR_MOD_CONTROL, 8'h31);
        env = 1'b1;
        settle();
        @(negedge clock);
        env = 1'b0;
        n = 0;
        while (modAct === 1'b1 && n < 100) begin
            @(negedge clock);
            n++;
        end
        chk("overshoot min", 11'h001, {10'h000, n >= 2 * CARRIER_DIV});
        chk("overshoot max", 11'h001, {10'h000, n <= 3 * CARRIER_DIV + 4});
        $display("test overshoot done");
    endtask : t_overshoot

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    initial begin
        #200000;
        errors++;
        test_done();
    end

    initial begin
        repeat (8) @(negedge clock);
        rst = 1'b0;
        t_regs();
        t_amp();
        t_pins();
        t_mod();
        t_overshoot();
        test_done();
    end
endmodule : rtc_tx_config_tb

`default_nettype wire

// ### core/rtc_mod_if.sv
`timescale 1ns/100ps
`default_nettype none

interface rtc_mod_if;
    logic [1:0] source;
    logic       invert;
    logic [3:0] overshootLen;
    logic       carrierTick;
    logic       internalEnvelope;
    logic       externalSignal;
    logic       modActive;

    modport cfg (
        output source, invert, overshootLen, carrierTick,
        output internalEnvelope, externalSignal,
        input  modActive
    );

    modport shaper (
        input  source, invert, overshootLen, carrierTick,
        input  internalEnvelope, externalSignal,
        output modActive
    );
endinterface : rtc_mod_if

`default_nettype wire

// ### core/rtc_mod_shaper.sv
`timescale 1ns/100ps
`default_nettype none

module rtc_mod_shaper (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // configuration and result
    rtc_mod_if.shaper bus
);
    import rtc_pkg::*;

    typedef enum logic {SH_IDLE, SH_EXTEND} rtc_shape_t;

    rtc_shape_t  state_q,  state_d;
    logic [3:0]  count_q,  count_d;
    logic        raw_q,    raw_d;
    logic        active_q, active_d;
    logic        chosen;
    logic        raw;

    // ****************************************
    // source select and shaping
    // ****************************************
    always_comb begin
        if (bus.source == SOURCE_ENVELOPE) begin
            chosen = bus.internalEnvelope;
        end else if (bus.source == SOURCE_EXTERNAL) begin
            chosen = bus.externalSignal;
        end else begin
            chosen = 1'b0;
        end
        // no source chosen means nothing to invert
        raw = (bus.source == SOURCE_ENVELOPE || bus.source == SOURCE_EXTERNAL)
              ? (chosen ^ bus.invert) : 1'b0;
        state_d  = state_q;
        count_d  = count_q;
        raw_d    = raw;
        case (state_q)
            SH_IDLE: begin
                if (raw_q && !raw && bus.overshootLen != 4'h0) begin
                    state_d = SH_EXTEND;
                    count_d = bus.overshootLen;
                end
            end
            SH_EXTEND: begin
                if (raw) begin
                    state_d = SH_IDLE;
                end else if (bus.carrierTick) begin
                    count_d = count_q - 4'h1;
                    if (count_q == 4'h1) begin
                        state_d = SH_IDLE;
                    end
                end
            end
            default: state_d = SH_IDLE;
        endcase
        active_d = raw | (state_d == SH_EXTEND);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q  <= SH_IDLE;
            count_q  <= 4'h0;
            raw_q    <= 1'b0;
            active_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            count_q  <= count_d;
            raw_q    <= raw_d;
            active_q <= active_d;
        end
    end

    assign bus.modActive = active_q;

endmodule : rtc_mod_shaper

`default_nettype wire

// ### core/rtc_pkg.sv
package rtc_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_DRIVE_MODE   = 8'h28;
    localparam logic [7:0] ADDR_AMPLITUDE    = 8'h29;
    localparam logic [7:0] ADDR_MOD_CONTROL  = 8'h2A;

    localparam logic [7:0] DRIVE_MODE_RESET  = 8'h00;
    localparam logic [7:0] AMPLITUDE_RESET   = 8'h00;
    localparam logic [7:0] MOD_CONTROL_RESET = 8'h00;

    // reserved bits masked away on write
    localparam logic [7:0] DRIVE_MODE_MASK   = 8'hCF;
    localparam logic [7:0] AMPLITUDE_MASK    = 8'hDF;
    localparam logic [7:0] MOD_CONTROL_MASK  = 8'hFF;
    localparam logic [7:0] READ_UNMAPPED     = 8'h00;

    // ****************************************
    // field positions
    // ****************************************
    localparam int SECOND_DRIVER_INVERT_BIT = 7;
    localparam int FIRST_DRIVER_INVERT_BIT  = 6;
    localparam int DRIVER_PINS_ENABLE_BIT   = 3;
    localparam int OUTPUT_MODE_MSB          = 2;
    localparam int OUTPUT_MODE_LSB          = 0;
    localparam int LEVEL_REDUCTION_MSB      = 7;
    localparam int LEVEL_REDUCTION_LSB      = 6;
    localparam int RESIDUAL_MSB             = 4;
    localparam int RESIDUAL_LSB             = 0;
    localparam int OVERSHOOT_MSB            = 7;
    localparam int OVERSHOOT_LSB            = 4;
    localparam int CARRIER_MAX_BIT          = 3;
    localparam int MOD_INVERT_BIT           = 2;
    localparam int SOURCE_MSB               = 1;
    localparam int SOURCE_LSB               = 0;

    // ****************************************
    // driver output modes
    // ****************************************
    localparam logic [2:0] MODE_HIGH_Z      = 3'h0;
    localparam logic [2:0] MODE_OPEN_DRAIN  = 3'h1;
    localparam logic [2:0] MODE_PUSH_PULL   = 3'h2;
    localparam logic [2:0] MODE_FORCE_LOW   = 3'h4;
    localparam logic [2:0] MODE_FORCE_HIGH  = 3'h5;

    // ****************************************
    // modulation sources
    // ****************************************
    localparam logic [1:0] SOURCE_NONE      = 2'h0;
    localparam logic [1:0] SOURCE_ENVELOPE  = 2'h1;
    localparam logic [1:0] SOURCE_EXTERNAL  = 2'h2;

    // ****************************************
    // carrier level drop below supply, mV
    // ****************************************
    localparam logic [10:0] DROP_MV_0       = 11'h064;
    localparam logic [10:0] DROP_MV_1       = 11'h0FA;
    localparam logic [10:0] DROP_MV_2       = 11'h1F4;
    localparam logic [10:0] DROP_MV_3       = 11'h3E8;
    localparam logic [10:0] DROP_MV_NONE    = 11'h000;

    // ****************************************
    // carrier timing
    // ****************************************
    localparam int CLOCK_KHZ   = 200000;
    localparam int CARRIER_KHZ = 13560;
    localparam int CARRIER_DIV = CLOCK_KHZ / CARRIER_KHZ;
    localparam logic [3:0] CARRIER_HALF = 4'(CARRIER_DIV / 2);

endpackage : rtc_pkg

// ### core/rtc_tx_config.sv
// Summary of operation
// - Drive-mode bit 7 inverts the signal on the second driver pin.
// - Drive-mode bit 6 inverts the signal on the first driver pin.
// - Drive-mode bit 3 enables both driver pins together, clear disables both.
// - The 3-bit output mode picks open-drain, push-pull, high-Z, forced high or low; 011b, 110b, 111b unused.
// - Amplitude bits 7:6 drop the carrier 100, 250, 500 or 1000 mV below the supply.
// - Modulation-control bit 3 drives the carrier at maximum and overrides the drop field.
// - Amplitude bits 4:0 are the residual carrier setting driven out to the analog stage; the modulation shaper never sees it.
// - Modulation-control bits 7:4 give the overshoot modulation length in carrier cycles.
// - Modulation-control bit 2 inverts the modulation chosen by the source field.
// - Source 00b is no modulation, 01b the internal envelope, 10b the external input; 11b unused.
`timescale 1ns/100ps
`default_nettype none

module rtc_tx_config (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,

    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic [7:0]  regWriteData,
    input  wire logic        regRead,
    output var  logic [7:0]  regReadData,
    output var  logic        regReadValid,

    // modulation sources
    input  wire logic        internalTransmitEnvelope,
    input  wire logic        externalSignalInput,

    // driver pins
    output var  logic        firstDriverPinOut,
    output var  logic        firstDriverPinOe,
    output var  logic        secondDriverPinOut,
    output var  logic        secondDriverPinOe,

    // analog stage controls
    output var  logic [1:0]  carrierLevelReduction,
    output var  logic        carrierAtMaximum,
    output var  logic [10:0] carrierDropMv,
    output var  logic [4:0]  residualCarrierSetting,
    output var  logic        modulationActive
);
    import rtc_pkg::*;

    // ****************************************
    // pin drive decode
    // ****************************************
    // returns {level, enable}; unsupported codes float the pin
    function automatic logic [1:0] pinDrive(
        input logic [2:0] mode,
        input logic       enable,
        input logic       sig
    );
        logic [1:0] result;
        result = 2'h0;
        if (!enable) begin
            result = 2'h0;
        end else if (mode == MODE_PUSH_PULL) begin
            result = {sig, 1'b1};
        end else if (mode == MODE_OPEN_DRAIN) begin
            result = {1'b0, ~sig};
        end else if (mode == MODE_FORCE_HIGH) begin
            result = 2'h3;
        end else if (mode == MODE_FORCE_LOW) begin
            result = 2'h1;
        end else begin
            result = 2'h0;
        end
        return result;
    endfunction : pinDrive

    // ****************************************
    // register state
    // ****************************************
    logic [7:0] driveMode_q,    driveMode_d;
    logic [7:0] amplitude_q,    amplitude_d;
    logic [7:0] modControl_q,   modControl_d;
    logic [7:0] readData_q,     readData_d;
    logic       readValid_q,    readValid_d;

    always_comb begin
        driveMode_d  = driveMode_q;
        amplitude_d  = amplitude_q;
        modControl_d = modControl_q;
        if (regWrite) begin
            if (regAddr == ADDR_DRIVE_MODE) begin
                driveMode_d = regWriteData & DRIVE_MODE_MASK;
            end else if (regAddr == ADDR_AMPLITUDE) begin
                amplitude_d = regWriteData & AMPLITUDE_MASK;
            end else if (regAddr == ADDR_MOD_CONTROL) begin
                modControl_d = regWriteData & MOD_CONTROL_MASK;
            end
        end
        readData_d  = READ_UNMAPPED;
        readValid_d = regRead;
        if (regRead) begin
            if (regAddr == ADDR_DRIVE_MODE) begin
                readData_d = driveMode_q;
            end else if (regAddr == ADDR_AMPLITUDE) begin
                readData_d = amplitude_q;
            end else if (regAddr == ADDR_MOD_CONTROL) begin
                readData_d = modControl_q;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            driveMode_q  <= DRIVE_MODE_RESET;
            amplitude_q  <= AMPLITUDE_RESET;
            modControl_q <= MOD_CONTROL_RESET;
            readData_q   <= READ_UNMAPPED;
            readValid_q  <= 1'b0;
        end else begin
            driveMode_q  <= driveMode_d;
            amplitude_q  <= amplitude_d;
            modControl_q <= modControl_d;
            readData_q   <= readData_d;
            readValid_q  <= readValid_d;
        end
    end

    assign regReadData  = readData_q;
    assign regReadValid = readValid_q;

    // ****************************************
    // carrier divider
    // ****************************************
    // the integer divide runs the carrier slightly fast; good enough
    // for overshoot timing, not a frequency reference
    logic [3:0] divCount_q,   divCount_d;
    logic       phase_q,      phase_d;
    logic       tick_q,       tick_d;

    always_comb begin
        divCount_d = divCount_q + 4'h1;
        phase_d    = phase_q;
        tick_d     = 1'b0;
        if (divCount_q == CARRIER_HALF - 4'h1) begin
            divCount_d = 4'h0;
            phase_d    = ~phase_q;
            tick_d     = phase_q;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            divCount_q <= 4'h0;
            phase_q    <= 1'b0;
            tick_q     <= 1'b0;
        end else begin
            divCount_q <= divCount_d;
            phase_q    <= phase_d;
            tick_q     <= tick_d;
        end
    end

    // ****************************************
    // modulation shaping
    // ****************************************
    rtc_mod_if modBus ();

    assign modBus.source = modControl_q[SOURCE_MSB:SOURCE_LSB];
    assign modBus.invert = modControl_q[MOD_INVERT_BIT];
    assign modBus.overshootLen = modControl_q[OVERSHOOT_MSB:OVERSHOOT_LSB];
    assign modBus.carrierTick = tick_q;
    assign modBus.internalEnvelope = internalTransmitEnvelope;
    assign modBus.externalSignal = externalSignalInput;

    rtc_mod_shaper u_shaper (
        .clock (clock),
        .rst   (rst),
        .bus   (modBus.shaper)
    );

    // ****************************************
    // driver pins
    // ****************************************
    logic [1:0] firstDrive_q,  firstDrive_d;
    logic [1:0] secondDrive_q, secondDrive_d;
    logic       modActive_q,   modActive_d;
    logic       carrierSig;

    always_comb begin
        // full modulation pulls the carrier off the antenna
        carrierSig  = phase_q & ~modBus.modActive;
        modActive_d = modBus.modActive;
        firstDrive_d = pinDrive(
            driveMode_q[OUTPUT_MODE_MSB:OUTPUT_MODE_LSB],
            driveMode_q[DRIVER_PINS_ENABLE_BIT],
            carrierSig ^ driveMode_q[FIRST_DRIVER_INVERT_BIT]);
        secondDrive_d = pinDrive(
            driveMode_q[OUTPUT_MODE_MSB:OUTPUT_MODE_LSB],
            driveMode_q[DRIVER_PINS_ENABLE_BIT],
            carrierSig ^ driveMode_q[SECOND_DRIVER_INVERT_BIT]);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            firstDrive_q  <= 2'h0;
            secondDrive_q <= 2'h0;
            modActive_q   <= 1'b0;
        end else begin
            firstDrive_q  <= firstDrive_d;
            secondDrive_q <= secondDrive_d;
            modActive_q   <= modActive_d;
        end
    end

    assign firstDriverPinOut  = firstDrive_q[1];
    assign firstDriverPinOe   = firstDrive_q[0];
    assign secondDriverPinOut = secondDrive_q[1];
    assign secondDriverPinOe  = secondDrive_q[0];
    assign modulationActive   = modActive_q;

    // ****************************************
    // analog controls
    // ****************************************
    logic [1:0]  reduction_q, reduction_d;
    logic        atMax_q,     atMax_d;
    logic [10:0] dropMv_q,    dropMv_d;
    logic [4:0]  residual_q,  residual_d;

    always_comb begin
        atMax_d     = modControl_q[CARRIER_MAX_BIT];
        reduction_d = amplitude_q[LEVEL_REDUCTION_MSB:LEVEL_REDUCTION_LSB];
        residual_d  = amplitude_q[RESIDUAL_MSB:RESIDUAL_LSB];
        case (reduction_d)
            2'h0:    dropMv_d = DROP_MV_0;
            2'h1:    dropMv_d = DROP_MV_1;
            2'h2:    dropMv_d = DROP_MV_2;
            default: dropMv_d = DROP_MV_3;
        endcase
        if (atMax_d) begin
            reduction_d = 2'h0;
            dropMv_d    = DROP_MV_NONE;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            reduction_q <= 2'h0;
            atMax_q     <= 1'b0;
            dropMv_q    <= DROP_MV_0;
            residual_q  <= 5'h00;
        end else begin
            reduction_q <= reduction_d;
            atMax_q     <= atMax_d;
            dropMv_q    <= dropMv_d;
            residual_q  <= residual_d;
        end
    end

    assign carrierLevelReduction  = reduction_q;
    assign carrierAtMaximum       = atMax_q;
    assign carrierDropMv          = dropMv_q;
    assign residualCarrierSetting = residual_q;

endmodule : rtc_tx_config

`default_nettype wire
